// ==== src/sbf_pkg.sv ====
/*
  Shared constants for the streaming back-pressure buffer: stream field widths,
  buffer depths, core latency, register map and bus response codes.
  Assumes a single 20 MHz clock domain and an AXI4-Lite master with 32-bit data.
*/
`default_nettype none

package sbf_pkg;

  // ***************************************************************
  // stream shape and buffering
  // ***************************************************************
  localparam int SBF_DATA_W    = 16;
  localparam int SBF_CHAN_W    = 8;
  localparam int SBF_IN_DEPTH  = 16;
  localparam int SBF_OUT_DEPTH = 16;
  localparam int SBF_CORE_LAT  = 4;
  localparam int SBF_HWCNT_W   = 16;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam int          SBF_AXI_AW      = 8;
  localparam logic [7:0]  SBF_REG_THRESH  = 8'h00;
  localparam logic [7:0]  SBF_REG_STATUS  = 8'h04;
  localparam logic [7:0]  SBF_REG_HWCOUNT = 8'h08;
  localparam int          SBF_STAT_OUT_LSB = 0;
  localparam int          SBF_STAT_IN_LSB  = 8;
  localparam int          SBF_STAT_HW_BIT  = 16;
  localparam int          SBF_STAT_DV_BIT  = 17;
  localparam int          SBF_STAT_UA_BIT  = 18;
  localparam logic [1:0]  SBF_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SBF_RESP_SLVERR = 2'h2;

  // ***************************************************************
  // bus channel states
  // ***************************************************************
  typedef enum logic [1:0] {
    SBF_CH_IDLE = 2'b00,
    SBF_CH_TAKE = 2'b01,
    SBF_CH_RESP = 2'b10
  } sbf_ch_state_t;

endpackage

`default_nettype wire

// ==== src/sbf_top.sv ====
/*
  Streaming in/out adapters around a processing core, with a buffered input
  stage, per-field output buffers, a high-water throttle and an AXI4-Lite
  register slave. Assumes one clock (aclk), synchronous active-low reset, and a
  core that only hands over a result while core_out_accept is high.
*/
`default_nettype none

// ***************************************************************
// circular buffer with registered head and flags
// ***************************************************************
module sbf_fifo
  import sbf_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  input  wire logic          stall,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  input  wire logic [CW-1:0] thr,
  output logic [CW-1:0]      level,
  output logic               high_water,
  output logic               high_water_next
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           count;
    logic                    out_valid;
    logic [W-1:0]            out_data;
    logic                    in_ready;
    logic                    hw;
  } sbf_fifo_state_t;

  sbf_fifo_state_t st;
  sbf_fifo_state_t next_st;
  logic            push;
  logic            pop;

  always_comb begin
    next_st = st;
    push    = in_valid && st.in_ready;
    pop     = st.out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wptr] = in_data;
      next_st.wptr         = (st.wptr == LAST) ? '0 : st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = (st.rptr == LAST) ? '0 : st.rptr + 1'b1;
    end
    next_st.count     = st.count + CW'(push) - CW'(pop);
    // head is looked up from the next state so a word written to an empty
    // buffer appears on the output at the edge that writes it, never in the same cycle
    next_st.out_valid = (next_st.count != '0);
    next_st.out_data  = next_st.mem[next_st.rptr];
    next_st.hw        = (next_st.count >= thr);
    next_st.in_ready  = (next_st.count < FULL) && !stall;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready        = st.in_ready;
  assign out_valid       = st.out_valid;
  assign out_data        = st.out_data;
  assign level           = st.count;
  assign high_water      = st.hw;
  assign high_water_next = next_st.hw;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  no_overflow_a: assert property (st.count <= FULL)
    else $error("buffer occupancy above depth");
  head_hold_a: assert property (st.out_valid && !out_ready |=> st.out_valid && $stable(st.out_data))
    else $error("head word changed without a pop");
  ready_room_a: assert property (st.in_ready |-> st.count < FULL)
    else $error("ready raised with no free entry");

endmodule

// ***************************************************************
// top: adapters, buffers, throttle and register slave
// ***************************************************************
module sbf_top
  import sbf_pkg::*;
#(
  parameter int DATA_W    = SBF_DATA_W,
  parameter int CHAN_W    = SBF_CHAN_W,
  parameter int IN_DEPTH  = SBF_IN_DEPTH,
  parameter int OUT_DEPTH = SBF_OUT_DEPTH,
  parameter int CORE_LAT  = SBF_CORE_LAT,
  parameter int HWCNT_W   = SBF_HWCNT_W
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // upstream side
  input  wire logic                  upstream_valid,
  output logic                       upstream_accept,
  input  wire logic [DATA_W-1:0]     upstream_data,
  input  wire logic [CHAN_W-1:0]     upstream_channel,
  input  wire logic                  upstream_sop,
  input  wire logic                  upstream_eop,
  // core input side
  output logic                       core_in_valid,
  input  wire logic                  core_in_accept,
  output logic [DATA_W-1:0]          core_in_data,
  output logic [CHAN_W-1:0]          core_in_channel,
  output logic                       core_in_sop,
  output logic                       core_in_eop,
  // core output side
  input  wire logic                  core_out_valid,
  output logic                       core_out_accept,
  input  wire logic [DATA_W-1:0]     core_out_data,
  input  wire logic [CHAN_W-1:0]     core_out_channel,
  input  wire logic                  core_out_sop,
  input  wire logic                  core_out_eop,
  // downstream side
  output logic                       downstream_valid,
  input  wire logic                  downstream_accept,
  output logic [DATA_W-1:0]          downstream_data,
  output logic [CHAN_W-1:0]          downstream_channel,
  output logic                       downstream_sop,
  output logic                       downstream_eop,
  output logic                       fifo_high_water,
  // register bus
  input  wire logic [SBF_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [SBF_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int WORD_W = DATA_W + CHAN_W + 2;
  localparam int ICW    = $clog2(IN_DEPTH + 1);
  localparam int OCW    = $clog2(OUT_DEPTH + 1);
  // throttle must fire while CORE_LAT entries are still free
  localparam logic [OCW-1:0] THR_MAX = OCW'(OUT_DEPTH - CORE_LAT);
  localparam logic [ICW-1:0] IN_THR  = ICW'(IN_DEPTH);

  // ***************************************************************
  // input adapter with its own buffer
  // ***************************************************************
  logic [WORD_W-1:0] up_word;
  logic [WORD_W-1:0] core_in_word;
  logic [ICW-1:0]    in_level;
  logic              out_hw_next;

  assign up_word = {upstream_data, upstream_channel, upstream_sop, upstream_eop};

  // stall takes the output buffer's next high-water value so that the
  // registered accept drops on the very edge the flag rises
  sbf_fifo #(.W(WORD_W), .DEPTH(IN_DEPTH), .CW(ICW)) u_in_fifo (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .in_valid        (upstream_valid),
    .in_ready        (upstream_accept),
    .in_data         (up_word),
    .stall           (out_hw_next),
    .out_valid       (core_in_valid),
    .out_ready       (core_in_accept),
    .out_data        (core_in_word),
    .thr             (IN_THR),
    .level           (in_level),
    .high_water      (),
    .high_water_next ()
  );

  assign core_in_data    = core_in_word[2+CHAN_W +: DATA_W];
  assign core_in_channel = core_in_word[2 +: CHAN_W];
  assign core_in_sop     = core_in_word[1];
  assign core_in_eop     = core_in_word[0];

  // ***************************************************************
  // output adapter: one buffer per field, all driven alike
  // ***************************************************************
  logic [WORD_W-1:0] res_word;
  logic [WORD_W-1:0] dn_word;
  logic [3:0]        f_in_ready;
  logic [3:0]        f_out_valid;
  logic [3:0]        f_hw;
  logic [3:0]        f_hw_next;
  logic [OCW-1:0]    f_level [4];
  logic [OCW-1:0]    thr_eff;

  assign res_word = {core_out_data, core_out_channel, core_out_sop, core_out_eop};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_field
      localparam int FW = (g < 2) ? 1 : ((g == 2) ? CHAN_W : DATA_W);
      localparam int LO = (g < 2) ? g : ((g == 2) ? 2 : 2 + CHAN_W);
      sbf_fifo #(.W(FW), .DEPTH(OUT_DEPTH), .CW(OCW)) u_out_fifo (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .in_valid        (core_out_valid),
        .in_ready        (f_in_ready[g]),
        .in_data         (res_word[LO +: FW]),
        .stall           (1'b0),
        .out_valid       (f_out_valid[g]),
        .out_ready       (downstream_accept),
        .out_data        (dn_word[LO +: FW]),
        .thr             (thr_eff),
        .level           (f_level[g]),
        .high_water      (f_hw[g]),
        .high_water_next (f_hw_next[g])
      );
    end
  endgenerate

  assign core_out_accept    = f_in_ready[0];
  assign downstream_valid   = f_out_valid[0];
  assign downstream_data    = dn_word[2+CHAN_W +: DATA_W];
  assign downstream_channel = dn_word[2 +: CHAN_W];
  assign downstream_sop     = dn_word[1];
  assign downstream_eop     = dn_word[0];
  assign fifo_high_water    = f_hw[0];
  assign out_hw_next        = f_hw_next[0];

  // ***************************************************************
  // register slave state
  // ***************************************************************
  typedef struct packed {
    sbf_ch_state_t      wst;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    sbf_ch_state_t      rst;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [OCW-1:0]     thr;
    logic [HWCNT_W-1:0] hw_count;
  } sbf_top_state_t;

  sbf_top_state_t st;
  sbf_top_state_t next_st;
  logic [31:0]    rd_word;

  // a written threshold above the safe limit is clipped, not rejected
  assign thr_eff = (st.thr > THR_MAX) ? THR_MAX : st.thr;

  always_comb begin
    next_st = st;
    rd_word = '0;
    // count rising edges of the high-water flag
    if (out_hw_next && !f_hw[0]) begin
      next_st.hw_count = st.hw_count + 1'b1;
    end
    // write channel: address and data are taken together on one edge
    case (st.wst)
      SBF_CH_IDLE: begin
        if (s_axi_awvalid && s_axi_wvalid) begin
          next_st.wst     = SBF_CH_TAKE;
          next_st.awready = 1'b1;
          next_st.wready  = 1'b1;
        end
      end
      SBF_CH_TAKE: begin
        next_st.awready = 1'b0;
        next_st.wready  = 1'b0;
        next_st.bvalid  = 1'b1;
        next_st.wst     = SBF_CH_RESP;
        next_st.bresp   = SBF_RESP_OKAY;
        if (s_axi_awaddr == SBF_REG_THRESH) begin
          if (s_axi_wstrb[0]) begin
            next_st.thr = s_axi_wdata[OCW-1:0];
          end
        end else if (s_axi_awaddr != SBF_REG_STATUS && s_axi_awaddr != SBF_REG_HWCOUNT) begin
          next_st.bresp = SBF_RESP_SLVERR;
        end
      end
      SBF_CH_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.wst    = SBF_CH_IDLE;
        end
      end
      default: begin
        next_st.wst = SBF_CH_IDLE;
      end
    endcase
    // read channel
    case (s_axi_araddr)
      SBF_REG_THRESH: begin
        rd_word[OCW-1:0] = st.thr;
      end
      SBF_REG_STATUS: begin
        rd_word[SBF_STAT_OUT_LSB +: OCW] = f_level[0];
        rd_word[SBF_STAT_IN_LSB +: ICW]  = in_level;
        rd_word[SBF_STAT_HW_BIT]         = f_hw[0];
        rd_word[SBF_STAT_DV_BIT]         = f_out_valid[0];
        rd_word[SBF_STAT_UA_BIT]         = upstream_accept;
      end
      SBF_REG_HWCOUNT: begin
        rd_word[HWCNT_W-1:0] = st.hw_count;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    case (st.rst)
      SBF_CH_IDLE: begin
        if (s_axi_arvalid) begin
          next_st.rst     = SBF_CH_TAKE;
          next_st.arready = 1'b1;
        end
      end
      SBF_CH_TAKE: begin
        next_st.arready = 1'b0;
        next_st.rvalid  = 1'b1;
        next_st.rst     = SBF_CH_RESP;
        next_st.rdata   = rd_word;
        next_st.rresp   = (s_axi_araddr == SBF_REG_THRESH || s_axi_araddr == SBF_REG_STATUS
                           || s_axi_araddr == SBF_REG_HWCOUNT) ? SBF_RESP_OKAY : SBF_RESP_SLVERR;
      end
      SBF_CH_RESP: begin
        if (s_axi_rready) begin
          next_st.rvalid = 1'b0;
          next_st.rst    = SBF_CH_IDLE;
        end
      end
      default: begin
        next_st.rst = SBF_CH_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st     <= '0;
      st.thr <= THR_MAX;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking tcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arready && s_axi_arvalid;
  endsequence

  accept_throttle_a: assert property (fifo_high_water |-> !upstream_accept)
    else $error("upstream accepted while high water set");
  hw_level_a: assert property (fifo_high_water == (f_level[0] >= thr_eff))
    else $error("high water flag disagrees with occupancy");
  // the flag must already stand once only CORE_LAT entries remain free, whatever was written
  thr_limit_a: assert property (f_level[0] >= THR_MAX |-> fifo_high_water)
    else $error("occupancy at depth minus latency without high water");
  // accept is still low in the cycle right after reset release
  core_full_a: assert property (!core_out_accept |-> f_level[0] == OCW'(OUT_DEPTH) || !$past(aresetn))
    else $error("core refused while buffer has room");
  core_in_hold_a: assert property (core_in_valid && !core_in_accept |=> core_in_valid && $stable(core_in_word))
    else $error("core input word dropped before accept");
  dn_hold_a: assert property (downstream_valid && !downstream_accept |=> downstream_valid && $stable(dn_word))
    else $error("downstream word changed under back-pressure");
  reset_clear_a: assert property ($rose(aresetn) |-> !downstream_valid && !fifo_high_water && f_level[0] == '0)
    else $error("state not cleared by reset");
  wr_answer_a: assert property (s_wr_take |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response missing one cycle after take");
  rd_answer_a: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing one cycle after take");

endmodule

`default_nettype wire

// ==== verification/sbf_sink_model.sv ====
/*
  Downstream sink model for the streaming back-pressure buffer bench.
  Assumes one clock, synchronous active-low reset, and a bench that picks
  the accept pattern through mode between bursts.
*/
`default_nettype none

module sbf_sink_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] mode,
  output logic            downstream_accept
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************************
  // accept pattern: 0 stall, 1 always, 2 every other cycle
  // ***************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      downstream_accept <= 1'h0;
    end else begin
      case (mode)
        2'h0: downstream_accept <= 1'h0;
        2'h1: downstream_accept <= 1'h1;
        default: downstream_accept <= ~downstream_accept;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== verification/test_sbf_top.sv ====
/*
  Self-checking bench for sbf_top: stream bursts, back-pressure and registers.
  Assumes the core is a zero-latency loopback that honours core_out_accept.
*/
`default_nettype none

module test_sbf_top;
  import sbf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  aclk = 1'h0;
  logic                  aresetn = 1'h0;
  logic                  upstream_valid = 1'h0;
  logic                  upstream_accept;
  logic [SBF_DATA_W-1:0] upstream_data = 16'h0000;
  logic [SBF_CHAN_W-1:0] upstream_channel = 8'h00;
  logic                  upstream_sop = 1'h0;
  logic                  upstream_eop = 1'h0;
  logic                  core_in_valid;
  logic                  core_out_accept;
  logic [SBF_DATA_W-1:0] core_in_data;
  logic [SBF_CHAN_W-1:0] core_in_channel;
  logic                  core_in_sop;
  logic                  core_in_eop;
  logic                  downstream_valid;
  logic                  downstream_accept;
  logic [SBF_DATA_W-1:0] downstream_data;
  logic [SBF_CHAN_W-1:0] downstream_channel;
  logic                  downstream_sop;
  logic                  downstream_eop;
  logic                  fifo_high_water;
  logic [7:0]            s_axi_awaddr = 8'h00;
  logic                  s_axi_awvalid = 1'h0;
  logic                  s_axi_awready;
  logic [31:0]           s_axi_wdata = 32'h0;
  logic [3:0]            s_axi_wstrb = 4'hF;
  logic                  s_axi_wvalid = 1'h0;
  logic                  s_axi_wready;
  logic [1:0]            s_axi_bresp;
  logic                  s_axi_bvalid;
  logic                  s_axi_bready = 1'h0;
  logic [7:0]            s_axi_araddr = 8'h00;
  logic                  s_axi_arvalid = 1'h0;
  logic                  s_axi_arready;
  logic [31:0]           s_axi_rdata;
  logic [1:0]            s_axi_rresp;
  logic                  s_axi_rvalid;
  logic                  s_axi_rready = 1'h0;
  logic [1:0]            mode = 2'h0;
  logic [25:0]           exp_q[$];
  logic [25:0]           got_q[$];
  int                    miscompares = 0;
  int                    n_tests = 0;
  int                    gidx = 0;
  int                    cyc = 0;

  // the core is a plain wire loop, so its latency is well below the threshold margin
  sbf_top uut (.aclk, .aresetn, .upstream_valid, .upstream_accept, .upstream_data, .upstream_channel,
    .upstream_sop, .upstream_eop, .core_in_valid, .core_in_accept(core_out_accept), .core_in_data,
    .core_in_channel, .core_in_sop, .core_in_eop, .core_out_valid(core_in_valid), .core_out_accept,
    .core_out_data(core_in_data), .core_out_channel(core_in_channel), .core_out_sop(core_in_sop),
    .core_out_eop(core_in_eop), .downstream_valid, .downstream_accept, .downstream_data, .downstream_channel,
    .downstream_sop, .downstream_eop, .fifo_high_water, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  sbf_sink_model sink (.aclk, .aresetn, .mode, .downstream_accept);

  always #25 aclk = ~aclk;

  always @(posedge aclk) begin
    if (aresetn && downstream_valid === 1'h1 && downstream_accept)
      got_q.push_back({downstream_data, downstream_channel, downstream_sop, downstream_eop});
  end

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic summarize();
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    r = 2'h3;
    for (int k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  // one packet of n words; gives up on a word after lim edges without accept
  task automatic send(input int n, input int lim, output int cnt);
    logic [25:0] w;
    bit          ok;
    cnt = 0;
    upstream_valid <= 1'h1;
    for (int i = 0; i < n; i++) begin
      w = {16'hA000 + 16'(gidx), 8'(gidx * 5), i == 0, i == n - 1};
      {upstream_data, upstream_channel, upstream_sop, upstream_eop} <= w;
      ok = 0;
      for (int k = 0; k < lim && !ok; k++) begin
        @(posedge aclk);
        ok = (upstream_accept === 1'h1);
      end
      if (!ok) break;
      exp_q.push_back(w);
      cnt++;
      gidx++;
    end
    upstream_valid <= 1'h0;
  endtask

  task automatic drain(input logic [1:0] m);
    mode <= m;
    for (int k = 0; k < 300 && got_q.size() < exp_q.size(); k++) @(posedge aclk);
    chk("count", exp_q.size(), got_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) chk("word", exp_q.pop_front(), got_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("dvalid", 32'h0, downstream_valid);
    chk("hw", 32'h0, fifo_high_water);
    axi_rd(SBF_REG_THRESH, d, r);
    chk("thresh", 32'(SBF_OUT_DEPTH - SBF_CORE_LAT), d);
    chk("rresp", SBF_RESP_OKAY, r);
    axi_rd(SBF_REG_STATUS, d, r);
    chk("status", 32'h1 << SBF_STAT_UA_BIT, d);
    axi_rd(8'h0C, d, r);
    chk("rresp", SBF_RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    axi_wr(8'h0C, 32'h1, 4'hF, r);
    chk("bresp", SBF_RESP_SLVERR, r);
    send(6, 20, n);
    drain(2'h1);
    send(6, 20, n);
    drain(2'h2);
    axi_wr(SBF_REG_THRESH, 32'h4, 4'hF, r);
    chk("bresp", SBF_RESP_OKAY, r);
    mode <= 2'h0;
    send(3, 20, n);
    repeat (6) @(posedge aclk);
    chk("hw", 32'h0, fifo_high_water);
    send(1, 20, n);
    repeat (4) @(posedge aclk);
    chk("hw", 32'h1, fifo_high_water);
    chk("ua", 32'h0, upstream_accept);
    send(1, 10, n);
    chk("refused", 32'h0, n);
    axi_rd(SBF_REG_HWCOUNT, d, r);
    chk("hwcount", 32'h1, d);
    drain(2'h1);
    repeat (2) @(posedge aclk);
    chk("hw", 32'h0, fifo_high_water);
    axi_wr(SBF_REG_THRESH, 32'h1F, 4'hF, r);
    axi_wr(SBF_REG_THRESH, 32'h5, 4'hE, r);
    axi_rd(SBF_REG_THRESH, d, r);
    chk("thresh", 32'h1F, d);
    mode <= 2'h0;
    send(40, 20, n);
    chk("hw", 32'h1, fifo_high_water);
    chk("enough", 32'h1, n >= SBF_OUT_DEPTH - SBF_CORE_LAT);
    chk("bounded", 32'h1, n <= SBF_OUT_DEPTH + SBF_IN_DEPTH);
    axi_rd(SBF_REG_STATUS, d, r);
    chk("outlvl", 32'h1, d[4:0] <= 5'(SBF_OUT_DEPTH));
    axi_rd(SBF_REG_HWCOUNT, d, r);
    chk("hwcount", 32'h2, d);
    drain(2'h1);
    // reset in mid-run with words still buffered: everything must come back empty
    mode <= 2'h0;
    send(3, 20, n);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("dvalid", 32'h0, downstream_valid);
    chk("hw", 32'h0, fifo_high_water);
    axi_rd(SBF_REG_STATUS, d, r);
    chk("status", 32'h1 << SBF_STAT_UA_BIT, d);
    axi_rd(SBF_REG_HWCOUNT, d, r);
    chk("hwcount", 32'h0, d);
    exp_q.delete();
    summarize();
  end
endmodule

`default_nettype wire
